// [core/pdu_defines.vh]
// constants for the divide and increment/decrement unit
`ifndef PDU_DEFINES_VH
`define PDU_DEFINES_VH
// ==================================================
// register byte offsets
`define PDU_OFF_CTRL 8'h00
`define PDU_OFF_ACC 8'h04
`define PDU_OFF_STACK 8'h08
`define PDU_OFF_OPLO 8'h0C
`define PDU_OFF_OPHI 8'h10
`define PDU_OFF_STATUS 8'h14
// ==================================================
// command register fields
`define PDU_CTRL_OP_MSB 2
`define PDU_CTRL_CONST 3
`define PDU_CTRL_PTR 4
`define PDU_CTRL_PTROK 5
`define PDU_CTRL_W 6
`define PDU_OP_NONE 3'h0
`define PDU_OP_DIV 3'h1
`define PDU_OP_BCD_QUOTIENT_DOUBLE 3'h2
`define PDU_OP_REAL_QUOTIENT 3'h3
`define PDU_OP_INC 3'h4
`define PDU_OP_DEC 3'h5
// ==================================================
// status flag positions
`define PDU_F_RANGE 0
`define PDU_F_ZERO 1
`define PDU_F_NEG 2
`define PDU_F_BADPTR 3
`define PDU_F_VALIDR 4
`define PDU_F_SIGNERR 5
`define PDU_F_UNDER 6
`define PDU_F_BADNUM 7
`define PDU_F_BUSY 8
// ==================================================
// reset values and timing counts
`define PDU_RST_WORD 32'h0000_0000
`define PDU_RST_FLAGS 8'h00
`define PDU_BCD_STEPS 6'h20
`define PDU_REAL_STEPS 5'h19
`define PDU_EXP_BIAS 10'h07F
`define PDU_RESP_OK 2'h0
`define PDU_RESP_ERR 2'h2
`endif

// [core/pdu_bcd_div.v]
// iterative unsigned binary divider for the bcd divides
`timescale 1ns/10ps
`default_nettype none
`include "pdu_defines.vh"
module pdu_bcd_div (
  input wire clk,
  input wire arst_n,
  input wire start,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output reg done,
  output reg [31:0] quot,
  output reg [31:0] rem
);
  // ==================================================
  // restoring divide, one quotient bit per cycle
  reg busy; // run in progress
  reg [5:0] cnt; // bits left
  reg [31:0] dvs; // held divisor
  wire [32:0] trial = {rem[31:0], quot[31]} - {1'b0, dvs}; // shifted remainder minus divisor

  // caller guarantees divisor is non-zero before start
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      cnt <= 6'h00;
      dvs <= `PDU_RST_WORD;
      quot <= `PDU_RST_WORD;
      rem <= `PDU_RST_WORD;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        cnt <= `PDU_BCD_STEPS;
        dvs <= divisor;
        quot <= dividend;
        rem <= `PDU_RST_WORD;
      end else if (busy) begin
        // bit fits: keep difference, shift a one in
        if (!trial[32]) begin
          rem <= trial[31:0];
          quot <= {quot[30:0], 1'b1};
        end else begin
          rem <= {rem[30:0], quot[31]};
          quot <= {quot[30:0], 1'b0};
        end
        cnt <= cnt - 6'h01;
        if (cnt == 6'h01) begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [core/pdu_real_div.v]
// iterative single precision divider, truncating, flush to zero
`timescale 1ns/10ps
`default_nettype none
`include "pdu_defines.vh"
module pdu_real_div (
  input wire clk,
  input wire arst_n,
  input wire start,
  input wire [31:0] dividend,
  input wire [31:0] divisor,
  output reg done,
  output reg [31:0] quotient,
  output reg underflow,
  output reg notReal,
  output reg divZero
);
  // ==================================================
  // mantissa long division state
  reg busy; // run in progress
  reg [4:0] cnt; // quotient bits left
  reg [24:0] rem; // partial remainder
  reg [23:0] mb; // divisor mantissa
  reg [24:0] q; // quotient bits
  reg sgn; // result sign
  reg [9:0] expo; // biased exponent, two's complement
  wire [7:0] ea = dividend[30:23];
  wire [7:0] eb = divisor[30:23];
  wire fits = (rem >= {1'b0, mb}); // quotient bit is one
  wire [24:0] remNext = fits ? rem - {1'b0, mb} : rem;
  wire [9:0] expoAdj = q[24] ? expo : expo - 10'h001; // normalised exponent

  // specials resolve in one cycle, finite pairs take 26
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
      cnt <= 5'h00;
      rem <= 25'h0;
      mb <= 24'h0;
      q <= 25'h0;
      sgn <= 1'b0;
      expo <= 10'h000;
      done <= 1'b0;
      quotient <= `PDU_RST_WORD;
      underflow <= 1'b0;
      notReal <= 1'b0;
      divZero <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        underflow <= 1'b0;
        notReal <= (ea == 8'hFF) || (eb == 8'hFF);
        divZero <= (eb == 8'h00);
        sgn <= dividend[31] ^ divisor[31];
        // zero dividend gives zero; bad operands end at once
        if ((ea == 8'hFF) || (eb == 8'hFF) || (eb == 8'h00) || (ea == 8'h00)) begin
          quotient <= `PDU_RST_WORD;
          done <= 1'b1;
        end else begin
          busy <= 1'b1;
          cnt <= `PDU_REAL_STEPS;
          rem <= {2'b01, dividend[22:0]};
          mb <= {1'b1, divisor[22:0]};
          expo <= {2'b00, ea} - {2'b00, eb} + `PDU_EXP_BIAS;
        end
      end else if (busy && (cnt != 5'h00)) begin
        q <= {q[23:0], fits};
        rem <= {remNext[23:0], 1'b0};
        cnt <= cnt - 5'h01;
      end else if (busy) begin
        // normalise, then clamp exponent range
        busy <= 1'b0;
        done <= 1'b1;
        if (expoAdj[9] || (expoAdj == 10'h000)) begin
          underflow <= 1'b1;
          quotient <= {sgn, 31'h0};
        end else if (expoAdj >= 10'h0FF) begin
          quotient <= {sgn, 8'hFF, 23'h0};
        end else if (q[24]) begin
          quotient <= {sgn, expoAdj[7:0], q[23:1]};
        end else begin
          quotient <= {sgn, expoAdj[7:0], q[22:0]};
        end
      end
    end
  end
endmodule
`default_nettype wire

// [core/pdu_divide_incdec_unit.v]
// divide and increment/decrement unit with axi4-lite registers
// How it works
// - bcd divide by four digit word/constant
// - quotient to accumulator, remainder to stack
// - double bcd divide by two-word divisor
// - real divide, quotient to accumulator
// - bcd divide flags operand out of range
// - zero result sets zero flag
// - divides flag negative accumulator
// - non-bcd digit sets bad number flag
// - real divide flags invalid pointer
// - real divide flags valid real accumulator
// - real divide clears sign error flag
// - real divide flags underflow
// - real divide flags non-real operand
// - flag holds until its next driver
// - increment adds one to word
// - decrement subtracts one from word
`timescale 1ns/10ps
`default_nettype none
`include "pdu_defines.vh"
module pdu_divide_incdec_unit (
  input wire clk,
  input wire arst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg operandRangeFlag,
  output reg zeroFlag,
  output reg negativeFlag,
  output reg badPointerFlag,
  output reg validRealFlag,
  output reg signErrorFlag,
  output reg underflowFlag,
  output reg badNumberFlag,
  output reg busy
);
  // ==================================================
  // engine states
  localparam ST_IDLE = 2'b01;
  localparam ST_WAIT = 2'b10;

  // ==================================================
  // helpers
  // every nibble a decimal digit
  function bcdOk;
    input [31:0] v;
    integer i;
    begin
      bcdOk = 1'b1;
      for (i = 0; i < 8; i = i + 1) begin
        if (v[i*4 +: 4] > 4'h9) begin
          bcdOk = 1'b0;
        end
      end
    end
  endfunction

  // eight digits to binary
  function [31:0] bcdToBin;
    input [31:0] v;
    integer i;
    begin
      bcdToBin = 32'h0;
      for (i = 7; i >= 0; i = i - 1) begin
        bcdToBin = (bcdToBin << 3) + (bcdToBin << 1) + {28'h0, v[i*4 +: 4]};
      end
    end
  endfunction

  // binary below 10^8 to eight digits, shift-add-three
  function [31:0] binToBcd;
    input [31:0] v;
    integer i;
    integer j;
    begin
      binToBcd = 32'h0;
      for (i = 31; i >= 0; i = i - 1) begin
        for (j = 0; j < 8; j = j + 1) begin
          if (binToBcd[j*4 +: 4] > 4'h4) begin
            binToBcd[j*4 +: 4] = binToBcd[j*4 +: 4] + 4'h3;
          end
        end
        binToBcd = {binToBcd[30:0], v[i]};
      end
    end
  endfunction

  // four digit step by one, wraps 9999 to 0000 and back
  function [15:0] bcdStep;
    input [15:0] v;
    input down;
    integer i;
    reg carry;
    begin
      bcdStep = v;
      carry = 1'b1;
      for (i = 0; i < 4; i = i + 1) begin
        if (carry && !down) begin
          carry = (v[i*4 +: 4] == 4'h9);
          bcdStep[i*4 +: 4] = carry ? 4'h0 : v[i*4 +: 4] + 4'h1;
        end else if (carry) begin
          carry = (v[i*4 +: 4] == 4'h0);
          bcdStep[i*4 +: 4] = carry ? 4'h9 : v[i*4 +: 4] - 4'h1;
        end
      end
    end
  endfunction

  // byte-lane merge of a bus write
  function [31:0] mergeStrb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        mergeStrb[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
      end
    end
  endfunction

  // ==================================================
  // architectural state
  reg [1:0] state; // engine state
  reg [31:0] acc; // accumulator
  reg [31:0] stack0; // first accumulator stack location
  reg [15:0] opLo; // operand word, low half
  reg [15:0] opHi; // following operand word
  reg [`PDU_CTRL_W-1:0] ctrl; // last command written
  reg [7:0] awAddr; // held write address
  reg awHeld; // write address taken
  reg [31:0] wData; // held write data
  reg [3:0] wStrb; // held byte enables
  reg wHeld; // write data taken
  reg bcdStart; // start pulse to bcd divider
  reg realStart; // start pulse to real divider

  reg [31:0] divisorBinHeld; // binary divisor held from the command on
  // operand words after byte lanes
  wire [31:0] loMerged = mergeStrb({16'h0, opLo}, wData, wStrb);
  wire [31:0] hiMerged = mergeStrb({16'h0, opHi}, wData, wStrb);
  wire bcdDone;
  wire [31:0] bcdQuot;
  wire [31:0] bcdRem;
  wire realDone;
  wire [31:0] realQuot;
  wire realUnder;
  wire realNotReal;
  wire realDivZero;

  // ==================================================
  // bus write decode
  wire doWrite = awHeld && wHeld && !s_axi_bvalid; // both halves in hand
  wire wrCtrl = doWrite && (awAddr == `PDU_OFF_CTRL) && wStrb[0];
  wire [2:0] newOp = wData[`PDU_CTRL_OP_MSB:0];
  // commands while busy are dropped, software polls busy
  wire cmdGo = wrCtrl && (state == ST_IDLE) && (newOp != `PDU_OP_NONE);
  wire newPtrBad = wData[`PDU_CTRL_PTR] && !wData[`PDU_CTRL_PTROK];
  wire wrMapped = (awAddr == `PDU_OFF_CTRL) || (awAddr == `PDU_OFF_ACC) ||
    (awAddr == `PDU_OFF_STACK) || (awAddr == `PDU_OFF_OPLO) ||
    (awAddr == `PDU_OFF_OPHI) || (awAddr == `PDU_OFF_STATUS);

  // ==================================================
  // operand selection
  // single divide uses one word, constant or memory alike
  wire [31:0] divisorBcd = (newOp == `PDU_OP_DIV) ? {16'h0, opLo} : {opHi, opLo};
  wire bcdBad = !bcdOk(acc) || !bcdOk(divisorBcd);
  wire [31:0] divisorBin = bcdToBin(divisorBcd);
  wire [15:0] stepped = bcdStep(opLo, newOp == `PDU_OP_DEC);
  wire [7:0] flagVec = {badNumberFlag, underflowFlag, signErrorFlag, validRealFlag,
    badPointerFlag, negativeFlag, zeroFlag, operandRangeFlag};

  // ==================================================
  // engine and register file, one writer per register
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
      acc <= `PDU_RST_WORD;
      stack0 <= `PDU_RST_WORD;
      opLo <= 16'h0;
      opHi <= 16'h0;
      ctrl <= {`PDU_CTRL_W{1'b0}};
      {badNumberFlag, underflowFlag, signErrorFlag, validRealFlag} <= 4'h0;
      {badPointerFlag, negativeFlag, zeroFlag, operandRangeFlag} <= 4'h0;
      bcdStart <= 1'b0;
      realStart <= 1'b0;
      busy <= 1'b0;
    end else begin
      bcdStart <= 1'b0;
      realStart <= 1'b0;
      // plain register writes; engine results below win
      if (doWrite) begin
        case (awAddr)
          `PDU_OFF_ACC: acc <= mergeStrb(acc, wData, wStrb);
          `PDU_OFF_STACK: stack0 <= mergeStrb(stack0, wData, wStrb);
          `PDU_OFF_OPLO: opLo <= loMerged[15:0];
          `PDU_OFF_OPHI: opHi <= hiMerged[15:0];
          default: ;
        endcase
        if (wrCtrl && (state == ST_IDLE)) begin
          ctrl <= wData[`PDU_CTRL_W-1:0];
        end
      end
      case (state)
        ST_IDLE: begin
          if (cmdGo) begin
            case (newOp)
              `PDU_OP_INC, `PDU_OP_DEC: begin
                // one step per command write, level holds not seen
                if (!newPtrBad) begin
                  badNumberFlag <= !bcdOk({16'h0, opLo});
                  if (bcdOk({16'h0, opLo})) begin
                    opLo <= stepped;
                    zeroFlag <= (stepped == 16'h0);
                  end
                end
              end
              `PDU_OP_DIV, `PDU_OP_BCD_QUOTIENT_DOUBLE: begin
                // constant mark ignored for the double form
                badNumberFlag <= bcdBad;
                operandRangeFlag <= !bcdBad && (divisorBin == 32'h0);
                if (!bcdBad && (divisorBin != 32'h0)) begin
                  bcdStart <= 1'b1;
                  busy <= 1'b1;
                  state <= ST_WAIT;
                end
              end
              `PDU_OP_REAL_QUOTIENT: begin
                badPointerFlag <= newPtrBad;
                if (!newPtrBad) begin
                  realStart <= 1'b1;
                  busy <= 1'b1;
                  state <= ST_WAIT;
                end
              end
              default: ;
            endcase
          end
        end
        ST_WAIT: begin
          if (bcdDone) begin
            acc <= binToBcd(bcdQuot);
            stack0 <= binToBcd(bcdRem);
            zeroFlag <= (bcdQuot == 32'h0);
            negativeFlag <= 1'b0;
            busy <= 1'b0;
            state <= ST_IDLE;
          end else if (realDone) begin
            // bad operand or zero divisor leave the accumulator alone
            badNumberFlag <= realNotReal;
            operandRangeFlag <= !realNotReal && realDivZero;
            underflowFlag <= realUnder;
            signErrorFlag <= 1'b0;
            if (!realNotReal && !realDivZero) begin
              acc <= realQuot;
              zeroFlag <= (realQuot[30:0] == 31'h0);
              negativeFlag <= realQuot[31];
              validRealFlag <= (realQuot[30:23] != 8'hFF);
            end else begin
              validRealFlag <= (acc[30:23] != 8'hFF);
            end
            busy <= 1'b0;
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // ==================================================
  // axi4-lite write channels, address and data in either order
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PDU_RESP_OK;
      awAddr <= 8'h00;
      awHeld <= 1'b0;
      wData <= `PDU_RST_WORD;
      wStrb <= 4'h0;
      wHeld <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr <= s_axi_awaddr;
        awHeld <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        wHeld <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      // unmapped offsets answer slverr and change nothing
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrMapped ? `PDU_RESP_OK : `PDU_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==================================================
  // axi4-lite read channel, answer one cycle after the address
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `PDU_RST_WORD;
      s_axi_rresp <= `PDU_RESP_OK;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `PDU_RESP_OK;
        case (s_axi_araddr)
          `PDU_OFF_CTRL: s_axi_rdata <= {26'h0, ctrl};
          `PDU_OFF_ACC: s_axi_rdata <= acc;
          `PDU_OFF_STACK: s_axi_rdata <= stack0;
          `PDU_OFF_OPLO: s_axi_rdata <= {16'h0, opLo};
          `PDU_OFF_OPHI: s_axi_rdata <= {16'h0, opHi};
          `PDU_OFF_STATUS: s_axi_rdata <= {23'h0, busy, flagVec};
          default: begin
            s_axi_rdata <= `PDU_RST_WORD;
            s_axi_rresp <= `PDU_RESP_ERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==================================================
  // dividers
  pdu_bcd_div uBcd (
    .clk(clk),
    .arst_n(arst_n),
    .start(bcdStart),
    .dividend(bcdToBin(acc)),
    .divisor(divisorBinHeld),
    .done(bcdDone),
    .quot(bcdQuot),
    .rem(bcdRem)
  );

  // divisor register, safe from later bus writes
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divisorBinHeld <= `PDU_RST_WORD;
    end else if (cmdGo) begin
      divisorBinHeld <= divisorBin;
    end
  end

  pdu_real_div uReal (
    .clk(clk),
    .arst_n(arst_n),
    .start(realStart),
    .dividend(acc),
    .divisor({opHi, opLo}),
    .done(realDone),
    .quotient(realQuot),
    .underflow(realUnder),
    .notReal(realNotReal),
    .divZero(realDivZero)
  );
endmodule
`default_nettype wire

// [core/pdu_unused_placeholder.v]
`timescale 1ns/10ps

// [test/pdu_divide_incdec_unit_props.sv]
// bus and flag checker for the divide and inc/dec unit
`timescale 1ns/10ps
`default_nettype none
module pdu_divide_incdec_unit_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic operandRangeFlag,
  input wire logic zeroFlag,
  input wire logic negativeFlag,
  input wire logic badPointerFlag,
  input wire logic validRealFlag,
  input wire logic signErrorFlag,
  input wire logic underflowFlag,
  input wire logic badNumberFlag,
  input wire logic busy
);
  // ==================================================
  // one clock domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==================================================
  // bus handshakes
  a_write_latency: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  a_write_blocked: assert property ($rose(s_axi_bvalid) |-> !s_axi_awready && !s_axi_wready)
    else $error("channels open");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("bresp dropped");
  a_resp_codes: assert property (s_axi_bvalid |-> s_axi_bresp inside {2'h0, 2'h2})
    else $error("bad bresp");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("rdata dropped");
  // ==================================================
  // divide engine and flags
  // longest divides, the single and double bcd, take 34 cycles
  a_busy_bounded: assert property ($rose(busy) |-> ##[1:40] !busy) else $error("divide never ends");
  // flags move only at a command or a divide end
  a_flags_change: assert property ($changed({badNumberFlag, underflowFlag, signErrorFlag, validRealFlag,
    badPointerFlag, negativeFlag, zeroFlag, operandRangeFlag}) |-> $rose(s_axi_bvalid) || $fell(busy))
    else $error("flag changed alone");
  a_sign_clear: assert property (!signErrorFlag) else $error("sign error flag set");
  // ==================================================
  // main scenarios reached
  c_divide_run: cover property ($rose(busy));
  c_zero_result: cover property ($rose(zeroFlag));
  c_slave_error: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule
bind pdu_divide_incdec_unit pdu_divide_incdec_unit_props u_props (.clk, .arst_n, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .operandRangeFlag, .zeroFlag, .negativeFlag, .badPointerFlag,
  .validRealFlag, .signErrorFlag, .underflowFlag, .badNumberFlag, .busy);
`default_nettype wire

// [test/pdu_divide_incdec_unit_tb_top.sv]
// self-checking bench for the divide and increment/decrement unit
`timescale 1ns/10ps
`default_nettype none
`include "pdu_defines.vh"
module pdu_divide_incdec_unit_tb_top;
  // ==================================================
  // stimulus and observed signals
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  // responses accepted at once
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, busy;
  wire logic [1:0] s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic operandRangeFlag, zeroFlag, negativeFlag, badPointerFlag;
  wire logic validRealFlag, signErrorFlag, underflowFlag, badNumberFlag;
  wire logic [7:0] flagVec = {badNumberFlag, underflowFlag, signErrorFlag, validRealFlag,
    badPointerFlag, negativeFlag, zeroFlag, operandRangeFlag};
  int nErrors = 0, cmpCount = 0;
  logic [1:0] resp;
  logic [31:0] rd;
  // row: ctrl, operands, expected words, mask (bit 8: words), flags
  typedef struct {logic [7:0] ctrl; logic [31:0] acc, lo, hi, eAcc, eStk, eLo; logic [8:0] mask;
    logic [7:0] flags;} pdu_row_t;
  pdu_row_t rows [0:17] = '{
    '{8'h01, 32'h100, 32'h7, 32'h0, 32'h14, 32'h2, 32'h7, 9'h187, 8'h00},
    '{8'h01, 32'h5, 32'h9, 32'h0, 32'h0, 32'h5, 32'h9, 9'h187, 8'h02},
    '{8'h02, 32'h12345678, 32'h0, 32'h1, 32'h1234, 32'h5678, 32'h0, 9'h187, 8'h00},
    '{8'h01, 32'h50, 32'h0, 32'h0, 32'h50, 32'h5678, 32'h0, 9'h101, 8'h01},
    '{8'h09, 32'h1A, 32'h2, 32'h0, 32'h1A, 32'h5678, 32'h2, 9'h181, 8'h80},
    '{8'h04, 32'h0, 32'h9, 32'h0, 32'h0, 32'h5678, 32'h10, 9'h182, 8'h00},
    '{8'h04, 32'h0, 32'h9999, 32'h0, 32'h0, 32'h5678, 32'h0, 9'h182, 8'h02},
    '{8'h05, 32'h0, 32'h0, 32'h0, 32'h0, 32'h5678, 32'h9999, 9'h182, 8'h00},
    '{8'h05, 32'h0, 32'h1, 32'h0, 32'h0, 32'h5678, 32'h0, 9'h182, 8'h02},
    '{8'h04, 32'h0, 32'hA0, 32'h0, 32'h0, 32'h5678, 32'hA0, 9'h182, 8'h82},
    '{8'h14, 32'h0, 32'h5, 32'h0, 32'h0, 32'h5678, 32'h5, 9'h182, 8'h82},
    '{8'h35, 32'h0, 32'h5, 32'h0, 32'h0, 32'h5678, 32'h4, 9'h182, 8'h00},
    '{8'h03, 32'h40C00000, 32'h0, 32'h4000, 32'h40400000, 32'h5678, 32'h0, 9'h1FE, 8'h10},
    '{8'h03, 32'hC0C00000, 32'h0, 32'h4000, 32'hC0400000, 32'h5678, 32'h0, 9'h1FE, 8'h14},
    '{8'h03, 32'h7FC00000, 32'h0, 32'h4000, 32'h0, 32'h0, 32'h0, 9'h080, 8'h80},
    '{8'h03, 32'h800000, 32'h0, 32'h4120, 32'h0, 32'h5678, 32'h0, 9'h1FE, 8'h52},
    '{8'h13, 32'h40C00000, 32'h0, 32'h4000, 32'h40C00000, 32'h5678, 32'h0, 9'h1FE, 8'h5A},
    '{8'h33, 32'h40C00000, 32'h0, 32'h4000, 32'h40400000, 32'h5678, 32'h0, 9'h1FE, 8'h10}};
  // ==================================================
  // clock and device
  always #50 clk = ~clk;
  pdu_divide_incdec_unit u_dut (.clk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .operandRangeFlag, .zeroFlag, .negativeFlag, .badPointerFlag, .validRealFlag, .signErrorFlag,
    .underflowFlag, .badNumberFlag, .busy);
  // ==================================================
  // bus tasks: aw and w together, each dropped once taken
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    r = s_axi_bresp;
    if (n >= 100) nErrors++;
  endtask
  task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    d = s_axi_rdata;
    r = s_axi_rresp;
    if (n >= 100) nErrors++;
  endtask
  // bounded wait for idle; a hang is an error
  task automatic waitIdle();
    int n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (busy && n < 200);
    if (busy) nErrors++;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finishTest();
    $display("errors %0d compares %0d", nErrors, cmpCount);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      axiWrite(`PDU_OFF_ACC, rows[i].acc, resp);
      axiWrite(`PDU_OFF_OPLO, rows[i].lo, resp);
      axiWrite(`PDU_OFF_OPHI, rows[i].hi, resp);
      axiWrite(`PDU_OFF_CTRL, {24'h0, rows[i].ctrl}, resp);
      waitIdle();
      check({24'h0, flagVec & rows[i].mask[7:0]}, {24'h0, rows[i].flags & rows[i].mask[7:0]});
      if (rows[i].mask[8]) begin
        axiRead(`PDU_OFF_ACC, rd, resp);
        check(rd, rows[i].eAcc);
        axiRead(`PDU_OFF_STACK, rd, resp);
        check(rd, rows[i].eStk);
        axiRead(`PDU_OFF_OPLO, rd, resp);
        check(rd, rows[i].eLo);
      end
    end
    // unmapped offsets answer slverr
    axiRead(8'h18, rd, resp);
    check(rd, 32'h0);
    check({30'h0, resp}, {30'h0, `PDU_RESP_ERR});
    axiWrite(8'h1C, 32'hFFFF, resp);
    check({30'h0, resp}, {30'h0, `PDU_RESP_ERR});
    // status is read only
    axiWrite(`PDU_OFF_STATUS, 32'hFF, resp);
    axiRead(`PDU_OFF_STATUS, rd, resp);
    check(rd, 32'h10);
    // a command while a divide runs is dropped
    axiWrite(`PDU_OFF_ACC, 32'h12345678, resp);
    axiWrite(`PDU_OFF_OPLO, 32'h1, resp);
    axiWrite(`PDU_OFF_OPHI, 32'h0, resp);
    axiWrite(`PDU_OFF_CTRL, 32'h2, resp);
    axiRead(`PDU_OFF_STATUS, rd, resp);
    check(rd & 32'h100, 32'h100);
    axiWrite(`PDU_OFF_CTRL, 32'h4, resp);
    waitIdle();
    axiRead(`PDU_OFF_OPLO, rd, resp);
    check(rd, 32'h1);
    axiRead(`PDU_OFF_ACC, rd, resp);
    check(rd, 32'h12345678);
    // reset in the middle of a divide clears everything
    axiWrite(`PDU_OFF_CTRL, 32'h2, resp);
    repeat (3) @(posedge clk);
    arst_n <= 1'b0;
    @(posedge clk);
    check({23'h0, busy, flagVec}, 32'h0);
    arst_n <= 1'b1;
    @(posedge clk);
    axiRead(`PDU_OFF_ACC, rd, resp);
    check(rd, 32'h0);
    finishTest();
  end
  // watchdog, well past the expected run
  initial begin
    #2000000;
    nErrors++;
    finishTest();
  end
endmodule
`default_nettype wire
